// >>> inc/ocf_pkg.sv
// constants shared by the overcurrent comparator fast filter
`default_nettype none
package ocf_pkg;
  // fast filter shape
  localparam int OSR = 64;                 // fixed decimation ratio
  localparam int OSR_W = 6;
  localparam logic [5:0] OSR_LAST = 6'(OSR - 1);
  localparam int CIC_W = 20;               // 3*log2(64) + sign + 1
  localparam int RES_W = 16;
  localparam int RES_SHIFT = 3;            // 2^18 full scale -> 2^15
  localparam logic [1:0] HIDE_N = 2'h2;    // unsettled outputs hidden
  // comparator settings
  localparam int NUM_W = 5;
  localparam int SECT_N = 2;
  localparam logic [15:0] POS_FULL = 16'h7FFF; // upper limit off
  localparam logic [15:0] NEG_FULL = 16'h8000; // lower limit off
  // flag layout: bit 2*section + offset, active low
  localparam int FLAG_UP = 0;
  localparam int FLAG_LO = 1;
  localparam logic [3:0] FLAGS_RST = 4'hF;
  localparam logic COMB_RST = 1'b1;
  // pin synchroniser depth and pwm half period in clk cycles
  localparam int SYNC_N = 3;
  localparam int PWM_HALF = 125;
endpackage
`default_nettype wire

// >>> hw/sinc3_fast_filter.sv
// sinc3 decimator with fixed ratio for one comparator section
`timescale 1ns/1ps
`default_nettype none
module sinc3_fast_filter (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // modulator side
  input  wire logic                        run_i,
  input  wire logic                        tick_i,
  input  wire logic                        bit_i,
  // result side
  output logic [ocf_pkg::RES_W-1:0]        result_o,
  output logic                             valid_o
);
  localparam int W = ocf_pkg::CIC_W;

  typedef struct packed {
    logic [W-1:0]                   int1;
    logic [W-1:0]                   int2;
    logic [W-1:0]                   int3;
    logic [W-1:0]                   dly1;
    logic [W-1:0]                   dly2;
    logic [W-1:0]                   dly3;
    logic [ocf_pkg::OSR_W-1:0]      phase;
    logic [1:0]                     hide;
    logic [ocf_pkg::RES_W-1:0]      result;
    logic                           valid;
  } filt_t;

  filt_t          st;
  filt_t          next_st;
  logic [W-1:0]   x;
  logic [W-1:0]   c1;
  logic [W-1:0]   c2;
  logic [W-1:0]   c3;
  logic [W-1:0]   scaled;

  // integrators at modulator rate, combs at output rate; wrap is harmless
  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    x = bit_i ? {{(W-1){1'b0}}, 1'b1} : '1;
    c1 = st.int3 - st.dly1;
    c2 = c1 - st.dly2;
    c3 = c2 - st.dly3;
    scaled = W'($signed(c3) >>> ocf_pkg::RES_SHIFT);
    if (!run_i) begin
      next_st = '0;
    end else if (tick_i) begin
      next_st.int1 = st.int1 + x;
      next_st.int2 = st.int2 + st.int1;
      next_st.int3 = st.int3 + st.int2;
      next_st.phase = st.phase + 1'b1;
      if (st.phase == ocf_pkg::OSR_LAST) begin
        next_st.dly1 = st.int3;
        next_st.dly2 = c1;
        next_st.dly3 = c2;
        if (st.hide != ocf_pkg::HIDE_N) begin
          next_st.hide = st.hide + 1'b1;
        end else begin
          next_st.valid = 1'b1;
          // +full scale overflows by one code, so clamp it
          if ($signed(scaled) >
              $signed({{(W-ocf_pkg::RES_W){1'b0}}, ocf_pkg::POS_FULL}))
            next_st.result = ocf_pkg::POS_FULL;
          else
            next_st.result = scaled[ocf_pkg::RES_W-1:0];
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign result_o = st.result;
  assign valid_o = st.valid;

  a_result_spacing: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    valid_o |=> !valid_o [*8])
    else $error("fast results closer than one decimation period");
endmodule
`default_nettype wire

// >>> hw/fault_pin_driver.sv
// drives one comparator fault pin with format and polarity choice
`timescale 1ns/1ps
`default_nettype none
module fault_pin_driver (
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  // fault and configuration
  input  wire logic  active_i,
  input  wire logic  direction_i,
  input  wire logic  source_sel_i,
  input  wire logic  format_i,
  input  wire logic  polarity_i,
  input  wire logic  pwm_tick_i,
  // pin
  output logic       pin_o,
  output logic       pin_oe_n_o
);
  typedef struct packed {
    logic  phase;
    logic  out;
    logic  oe_n;
  } pin_t;

  pin_t  st;
  pin_t  next_st;

  // active shows the static active level; inactive is static or pwm
  always_comb begin
    next_st = st;
    if (pwm_tick_i)
      next_st.phase = !st.phase;
    next_st.oe_n = !(direction_i && !source_sel_i);
    if (next_st.oe_n)
      next_st.out = 1'b0;
    else if (active_i)
      next_st.out = polarity_i;
    else if (format_i)
      next_st.out = st.phase;
    else
      next_st.out = !polarity_i;
  end

  // state register; pin released during reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      st <= '{phase: 1'b0, out: 1'b0, oe_n: 1'b1};
    else
      st <= next_st;
  end

  assign pin_o = st.out;
  assign pin_oe_n_o = st.oe_n;
endmodule
`default_nettype wire

// >>> hw/overcurrent_comparator_fast_filter.sv
// two digital overcurrent comparators with sinc3 fast filters
`timescale 1ns/1ps
`default_nettype none
module overcurrent_comparator_fast_filter #(
  parameter int PWM_HALF = ocf_pkg::PWM_HALF
) (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  // modulator pins, one clock shared by both sections
  input  wire logic                         mod_clk_i,
  input  wire logic [1:0]                   mod_data_i,
  // section control
  input  wire logic [1:0]                   current_adc_enable_i,
  input  wire logic [1:0]                   cmp_enable_i,
  input  wire logic [1:0][15:0]             cmp_upper_limit_i,
  input  wire logic [1:0][15:0]             cmp_lower_limit_i,
  input  wire logic [1:0][4:0]              cmp_exceed_count_i,
  // flag control, clear inputs are one-cycle write-one pulses
  input  wire logic [3:0]                   cmp_flag_mask_i,
  input  wire logic [3:0]                   detail_clear_i,
  input  wire logic                         combined_clear_i,
  // pin configuration
  input  wire logic                         pin3_direction_i,
  input  wire logic                         pin3_source_sel_i,
  input  wire logic                         pin3_format_i,
  input  wire logic                         cmp_a_pin_polarity_i,
  input  wire logic                         pin4_direction_i,
  input  wire logic                         pin4_source_sel_i,
  input  wire logic                         pin4_format_i,
  input  wire logic                         cmp_b_pin_polarity_i,
  // status
  output logic [3:0]                        cmp_detail_flags_o,
  output logic                              combined_overcurrent_flag_n_o,
  output logic [1:0][15:0]                  fast_result_o,
  output logic [1:0]                        fast_valid_o,
  // fault pins
  output logic                              pin3_o,
  output logic                              pin3_oe_n_o,
  output logic                              pin4_o,
  output logic                              pin4_oe_n_o
);
  localparam int SN = ocf_pkg::SECT_N;
  localparam int YN = ocf_pkg::SYNC_N;
  localparam int PW = $clog2(PWM_HALF + 1);
  localparam logic [PW-1:0] PWM_LAST = PW'(PWM_HALF - 1);

  typedef struct packed {
    logic [YN-1:0]                  clk_sync;
    logic                           clk_stable;
    logic [SN-1:0][YN-1:0]          dat_sync;
    logic [SN-1:0]                  dat_stable;
    logic                           tick;
    logic [SN-1:0]                  bits;
    logic [SN-1:0][ocf_pkg::NUM_W-1:0] run_cnt;
    logic [3:0]                     flag_n;
    logic                           comb_n;
    logic [PW-1:0]                  pwm_cnt;
    logic                           pwm_tick;
  } top_t;

  localparam top_t RST_ST = '{
    clk_sync:   '0,
    clk_stable: 1'b0,
    dat_sync:   '0,
    dat_stable: '0,
    tick:       1'b0,
    bits:       '0,
    run_cnt:    '0,
    flag_n:     ocf_pkg::FLAGS_RST,
    comb_n:     ocf_pkg::COMB_RST,
    pwm_cnt:    '0,
    pwm_tick:   1'b0
  };

  top_t                st;
  top_t                next_st;
  logic [SN-1:0][15:0] res;
  logic [SN-1:0]       vld;
  logic [SN-1:0]       hit_up;
  logic [SN-1:0]       hit_lo;
  logic [SN-1:0]       mod_tick;
  logic [3:0]          mask_hits;

  // one filter per section; a stopped adc stops its modulator ticks
  generate
    for (genvar y = 0; y < SN; y++) begin : g_sect
      assign mod_tick[y] = st.tick && current_adc_enable_i[y];
      // raw modulator stream only, no calibration stage in this path
      sinc3_fast_filter u_filt (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .run_i    (cmp_enable_i[y]),
        .tick_i   (mod_tick[y]),
        .bit_i    (st.bits[y]),
        .result_o (res[y]),
        .valid_o  (vld[y])
      );
    end
  endgenerate

  // next state of the whole block
  always_comb begin
    next_st = st;
    hit_up = '0;
    hit_lo = '0;

    // three-stage pin synchronisers; only stages two and three are judged
    next_st.clk_sync = {st.clk_sync[YN-2:0], mod_clk_i};
    for (int y = 0; y < SN; y++) begin
      next_st.dat_sync[y] = {st.dat_sync[y][YN-2:0], mod_data_i[y]};
      if (st.dat_sync[y][1] == st.dat_sync[y][2])
        next_st.dat_stable[y] = st.dat_sync[y][2];
    end

    // modulator rising edge becomes a one-cycle tick with its bits
    next_st.tick = 1'b0;
    if (st.clk_sync[1] == st.clk_sync[2] &&
        st.clk_sync[2] != st.clk_stable) begin
      next_st.clk_stable = st.clk_sync[2];
      next_st.tick = st.clk_sync[2];
      next_st.bits = st.dat_stable;
    end

    // host write of one releases detailed flags
    next_st.flag_n = st.flag_n | detail_clear_i;

    // threshold compare and consecutive counter per section
    for (int y = 0; y < SN; y++) begin
      hit_up[y] = $signed(res[y]) > $signed(cmp_upper_limit_i[y]);
      hit_lo[y] = $signed(res[y]) < $signed(cmp_lower_limit_i[y]);
      if (!cmp_enable_i[y]) begin
        next_st.run_cnt[y] = '0;
      end else if (vld[y]) begin
        if (hit_up[y] || hit_lo[y]) begin
          // set after the clear above, so a new fault wins
          if (st.run_cnt[y] >= cmp_exceed_count_i[y]) begin
            if (hit_up[y])
              next_st.flag_n[2*y + ocf_pkg::FLAG_UP] = 1'b0;
            if (hit_lo[y])
              next_st.flag_n[2*y + ocf_pkg::FLAG_LO] = 1'b0;
          end else begin
            next_st.run_cnt[y] = st.run_cnt[y] + 1'b1;
          end
        end else begin
          next_st.run_cnt[y] = '0;
        end
      end
    end

    // combined flag: clear only over all-high detail flags, set wins
    mask_hits = ~next_st.flag_n & ~cmp_flag_mask_i;
    if (combined_clear_i && (&st.flag_n))
      next_st.comb_n = 1'b1;
    if (|mask_hits)
      next_st.comb_n = 1'b0;

    // divider giving the pwm half-period enable
    next_st.pwm_tick = 1'b0;
    if (st.pwm_cnt == PWM_LAST) begin
      next_st.pwm_cnt = '0;
      next_st.pwm_tick = 1'b1;
    end else begin
      next_st.pwm_cnt = st.pwm_cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      st <= RST_ST;
    else
      st <= next_st;
  end

  // fault pins follow raw detail flags; masks are not wired here
  fault_pin_driver u_pin3 (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .active_i     (!(&st.flag_n[1:0])),
    .direction_i  (pin3_direction_i),
    .source_sel_i (pin3_source_sel_i),
    .format_i     (pin3_format_i),
    .polarity_i   (cmp_a_pin_polarity_i),
    .pwm_tick_i   (st.pwm_tick),
    .pin_o        (pin3_o),
    .pin_oe_n_o   (pin3_oe_n_o)
  );

  fault_pin_driver u_pin4 (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .active_i     (!(&st.flag_n[3:2])),
    .direction_i  (pin4_direction_i),
    .source_sel_i (pin4_source_sel_i),
    .format_i     (pin4_format_i),
    .polarity_i   (cmp_b_pin_polarity_i),
    .pwm_tick_i   (st.pwm_tick),
    .pin_o        (pin4_o),
    .pin_oe_n_o   (pin4_oe_n_o)
  );

  // status outputs straight from registers
  assign cmp_detail_flags_o = st.flag_n;
  assign combined_overcurrent_flag_n_o = st.comb_n;
  assign fast_result_o = res;
  assign fast_valid_o = vld;

  // counter must be empty one cycle after disable
  a_counter_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !cmp_enable_i[0] |=> st.run_cnt[0] == '0)
    else $error("exceedance counter not cleared by disable");

  // an inside result empties the counter
  a_inside_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmp_enable_i[1] && vld[1] && !hit_up[1] && !hit_lo[1]
    |=> st.run_cnt[1] == '0)
    else $error("inside result did not clear counter");

  // upper flag never falls while the upper limit sits at full scale
  a_upper_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(st.flag_n[0])
    |-> $past(cmp_upper_limit_i[0]) != ocf_pkg::POS_FULL)
    else $error("upper flag fell with upper limit disabled");

  // lower flag never falls while the lower limit sits at full scale
  a_lower_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(st.flag_n[1])
    |-> $past(cmp_lower_limit_i[0]) != ocf_pkg::NEG_FULL)
    else $error("lower flag fell with lower limit disabled");

  // every section b upper flag fall has a result above the limit behind it
  a_flag_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(st.flag_n[2]) |-> $past(vld[1]) && $past(cmp_enable_i[1]) &&
      $signed($past(res[1])) > $signed($past(cmp_upper_limit_i[1])))
    else $error("upper flag fell without an exceeding result");

  // with count zero one exceeding result is enough
  a_single_hit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmp_enable_i[0] && vld[0] && cmp_exceed_count_i[0] == '0 &&
    $signed(res[0]) > $signed(cmp_upper_limit_i[0])
    |=> !st.flag_n[0])
    else $error("single exceeding result did not flag");

  // a low flag stays low until the host writes one
  a_flag_latched: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !st.flag_n[3] && !detail_clear_i[3] |=> !st.flag_n[3])
    else $error("detailed flag released without a clear");

  // an unmasked low flag pulls the combined flag low
  a_combined_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !st.flag_n[1] && !cmp_flag_mask_i[1] && !detail_clear_i[1]
    |=> !st.comb_n)
    else $error("combined flag missed an unmasked fault");

  // combined flag refuses to clear over a low detailed flag
  a_combined_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !st.comb_n && !(&st.flag_n) |=> !st.comb_n)
    else $error("combined flag cleared over a detailed fault");

  // all masked: the combined flag cannot fall
  a_mask_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (&cmp_flag_mask_i) && st.comb_n |=> st.comb_n)
    else $error("masked fault reached combined flag");

  // pin3 static active-low shows a section a fault next cycle
  a_pin3_fault: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pin3_direction_i && !pin3_source_sel_i && !pin3_format_i &&
    !cmp_a_pin_polarity_i && !(&st.flag_n[1:0])
    |=> !pin3_o && !pin3_oe_n_o)
    else $error("pin3 not showing section a fault");

  // pin4 ignores masks and follows the lower flag, active high
  a_pin4_nomask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (&cmp_flag_mask_i) && !st.flag_n[3] && pin4_direction_i &&
    !pin4_source_sel_i && cmp_b_pin_polarity_i
    |=> pin4_o && !pin4_oe_n_o)
    else $error("pin4 fault hidden by mask");

  // section b counter is empty one cycle after disable
  a_counter_off_b: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !cmp_enable_i[1] |=> st.run_cnt[1] == '0)
    else $error("section b counter not cleared by disable");

  // section b upper flag stays high over a full-scale upper limit
  a_upper_off_b: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(st.flag_n[2])
    |-> $past(cmp_upper_limit_i[1]) != ocf_pkg::POS_FULL)
    else $error("section b upper flag fell with limit disabled");

  // section b lower flag stays high over a full-scale lower limit
  a_lower_off_b: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(st.flag_n[3])
    |-> $past(cmp_lower_limit_i[1]) != ocf_pkg::NEG_FULL)
    else $error("section b lower flag fell with limit disabled");

  // every section a lower flag fall has a result below the limit behind it
  a_lower_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(st.flag_n[1]) |-> $past(vld[0]) && $past(cmp_enable_i[0]) &&
      $signed($past(res[0])) < $signed($past(cmp_lower_limit_i[0])))
    else $error("lower flag fell without a result below the limit");

  // section b flags fall only in the cycle after a fast result
  a_fall_on_result: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(st.flag_n[2]) || $fell(st.flag_n[3]) |-> $past(vld[1]))
    else $error("section b flag fell without a fast result");

  // a nonzero count setting never flags on the first exceeding result
  a_count_waits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmp_enable_i[0] && vld[0] && cmp_exceed_count_i[0] != '0 &&
    st.run_cnt[0] == '0 && st.flag_n[0]
    |=> st.flag_n[0])
    else $error("flag fell before the count setting was reached");

  // the combined flag falls only over an unmasked low detailed flag
  a_comb_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(st.comb_n) |-> |(~st.flag_n & ~$past(cmp_flag_mask_i)))
    else $error("combined flag fell without an unmasked fault");

  // pin3 is released and low whenever it is not a fault output
  a_pin3_released: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(pin3_direction_i && !pin3_source_sel_i)
    |=> pin3_oe_n_o && !pin3_o)
    else $error("pin3 driven while not selected as fault output");

  // pin4 static format shows the inverse of its polarity without a fault
  a_pin4_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pin4_direction_i && !pin4_source_sel_i && !pin4_format_i &&
    (&st.flag_n[3:2])
    |=> pin4_o != $past(cmp_b_pin_polarity_i) && !pin4_oe_n_o)
    else $error("pin4 not at its inactive level");
endmodule
`default_nettype wire

// >>> testbench/mod_source.sv
// modulator model: one shared bit clock, one bitstream per section
`timescale 1ns/1ps
`default_nettype none
module mod_source (
  // control from the bench
  input  wire logic [1:0]      run_i,
  input  wire logic [1:0][8:0] dens_i,
  // modulator pins
  output logic                 mod_clk_o,
  output logic [1:0]           mod_data_o
);
  int seed;

  // clock stands still while no modulator runs; idle data keeps moving
  initial begin
    seed = 94;
    mod_clk_o = 1'b0;
    mod_data_o = 2'h0;
    forever begin
      if (run_i == 2'h0) begin
        #33;
        mod_data_o = ~mod_data_o;
      end else begin
        // bits launched at the falling edge, half a period from sampling
        for (int s = 0; s < 2; s++) begin
          if (run_i[s]) begin
            mod_data_o[s] = (($random(seed) & 255) < int'(dens_i[s]));
          end else begin
            mod_data_o[s] = ~mod_data_o[s];
          end
        end
        #33;
        mod_clk_o = 1'b1;
        #33;
        mod_clk_o = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/overcurrent_comparator_fast_filter_tb_top.sv
// self-checking bench for the overcurrent comparator fast filter
`timescale 1ns/1ps
`default_nettype none
module overcurrent_comparator_fast_filter_tb_top;
  logic             clk_i, rst_n_i, mclk, comb_clr, comb, mcomb;
  logic [1:0]       mdat, adc_en, cmp_en, valid, pdir, psrc, pfmt, ppol;
  logic [1:0]       poe, pout;
  logic [1:0][15:0] up, lwr, res;
  logic [1:0][4:0]  ncfg;
  logic [1:0][8:0]  dens;
  logic [3:0]       mask, dclr, flags, mflags;
  logic [15:0]      exp_q[2][$];
  int               seed, n_fail, checked, h[190], hist[2][$];
  int               ticks[2], cnt[2], exp_n[2], seen_n[2];

  mod_source mp_u (.run_i(adc_en), .dens_i(dens), .mod_clk_o(mclk),
                   .mod_data_o(mdat));

  overcurrent_comparator_fast_filter #(.PWM_HALF(4)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mod_clk_i(mclk), .mod_data_i(mdat),
    .current_adc_enable_i(adc_en), .cmp_enable_i(cmp_en),
    .cmp_upper_limit_i(up), .cmp_lower_limit_i(lwr),
    .cmp_exceed_count_i(ncfg), .cmp_flag_mask_i(mask),
    .detail_clear_i(dclr), .combined_clear_i(comb_clr),
    .pin3_direction_i(pdir[0]), .pin3_source_sel_i(psrc[0]),
    .pin3_format_i(pfmt[0]), .cmp_a_pin_polarity_i(ppol[0]),
    .pin4_direction_i(pdir[1]), .pin4_source_sel_i(psrc[1]),
    .pin4_format_i(pfmt[1]), .cmp_b_pin_polarity_i(ppol[1]),
    .cmp_detail_flags_o(flags), .combined_overcurrent_flag_n_o(comb),
    .fast_result_o(res), .fast_valid_o(valid),
    .pin3_o(pout[0]), .pin3_oe_n_o(poe[0]),
    .pin4_o(pout[1]), .pin4_oe_n_o(poe[1]));

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // inputs move 1 ns after the edge, away from sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // pwm idle level is not tracked, only static levels are compared
  task automatic check_state();
    check(32'(flags), 32'(mflags));
    check(32'(comb), 32'(mcomb));
    for (int s = 0; s < 2; s++) begin
      if (!(pdir[s] && !psrc[s])) begin
        check(32'({poe[s], pout[s]}), 32'h2);
      end else if (mflags[2*s+:2] != 2'h3) begin
        check(32'({poe[s], pout[s]}), 32'({1'b0, ppol[s]}));
      end else if (!pfmt[s]) begin
        check(32'({poe[s], pout[s]}), 32'({1'b0, ~ppol[s]}));
      end
    end
  endtask

  // reference sinc3: piecewise quadratic weights over 190 bits; the integrator
  // chain lags the stream, so the window ends three bits back
  function automatic logic [15:0] sinc3_ref(input int s);
    longint acc;
    int     idx;
    acc = 0;
    for (int k = 0; k < 190; k++) begin
      idx = hist[s].size() - 4 - k;
      if (idx >= 0) acc += h[k] * hist[s][idx];
    end
    acc = acc >>> 3;
    if (acc > 32767) acc = 32767;
    return 16'(acc);
  endfunction

  // reference filter input: one bit per modulator rising edge while enabled
  always @(posedge mclk) begin
    for (int s = 0; s < 2; s++) begin
      if (adc_en[s] && cmp_en[s]) begin
        hist[s].push_back(mdat[s] ? 1 : -1);
        if (hist[s].size() > 193) void'(hist[s].pop_front());
        ticks[s]++;
        if (ticks[s] >= 192 && ticks[s] % 64 == 0) begin
          exp_q[s].push_back(sinc3_ref(s));
          exp_n[s]++;
        end
      end
    end
  end

  // each result: state left by the last one, the value, then model update
  always @(posedge clk_i) begin
    logic [15:0] e;
    logic        hi, lo;
    if (valid !== 2'h0) check_state();
    for (int s = 0; s < 2; s++) begin
      if (valid[s] === 1'b1) begin
        seen_n[s]++;
        e = (exp_q[s].size() != 0) ? exp_q[s].pop_front() : 16'hXXXX;
        check(32'(res[s]), 32'(e));
        hi = $signed(e) > $signed(up[s]);
        lo = $signed(e) < $signed(lwr[s]);
        if (hi || lo) begin
          if (cnt[s] <= int'(ncfg[s])) cnt[s]++;
        end else begin
          cnt[s] = 0;
        end
        if (cnt[s] > int'(ncfg[s])) begin
          if (hi) mflags[2*s] = 1'b0;
          if (lo) mflags[2*s+1] = 1'b0;
        end
      end
    end
    if ((~mflags & ~mask) != 4'h0) mcomb = 1'b0;
  end

  // random section set-up; the first two are fixed full-scale cases
  task automatic setup(input int sc);
    int base;
    for (int s = 0; s < 2; s++) begin
      dens[s] = 9'(64 + ($random(seed) & 127));
      base = (int'(dens[s]) * 2 - 256) * 128;
      up[s] = 16'(base + ($random(seed) & 1023) - 256);
      lwr[s] = 16'(base - ($random(seed) & 1023) + 256);
      ncfg[s] = 5'($random(seed) & 3);
    end
    mask = 4'($random(seed));
    // last scenario keeps every flag away from the combined flag
    if (sc == 7) mask = 4'hF;
    {pdir, psrc, pfmt, ppol} = 8'($random(seed));
    if (sc < 2) begin
      dens = {9'h000, 9'h100};
      up = {16'h7FFF, 16'($random(seed)) & 16'h3FFF};
      lwr = {16'hC000 | 16'($random(seed)), 16'h8000};
      ncfg = 10'h000;
      mask = 4'h0;
      {pdir, psrc} = 4'hC;
    end
    if (sc == 1) begin
      up = {2{16'h7FFF}};
      lwr = {2{16'h8000}};
    end
  endtask

  // settings change only with the comparators disabled
  task automatic finish_sc();
    cmp_en = 2'h0;
    step(1);
    adc_en = 2'h0;
    step(40);
    check(32'(seen_n[0]), 32'(exp_n[0]));
    check(32'(seen_n[1]), 32'(exp_n[1]));
    check_state();
    comb_clr = 1'b1;
    step(1);
    comb_clr = 1'b0;
    if (mflags == 4'hF) mcomb = 1'b1;
    step(2);
    check_state();
    dclr = 4'hF;
    step(1);
    dclr = 4'h0;
    mflags = 4'hF;
    step(2);
    check_state();
    comb_clr = 1'b1;
    step(1);
    comb_clr = 1'b0;
    mcomb = 1'b1;
    step(2);
    check_state();
    for (int s = 0; s < 2; s++) begin
      hist[s].delete();
      exp_q[s].delete();
      ticks[s] = 0;
      cnt[s] = 0;
      exp_n[s] = 0;
      seen_n[s] = 0;
    end
  endtask

  // main sequence
  initial begin
    seed = 94;
    rst_n_i = 1'b0;
    {adc_en, cmp_en, dclr, comb_clr, mask} = '0;
    {up, lwr, ncfg, dens} = '0;
    {pdir, psrc, pfmt, ppol} = 8'h00;
    mflags = 4'hF;
    mcomb = 1'b1;
    for (int a = 0; a < 64; a++)
      for (int b = 0; b < 64; b++)
        for (int c = 0; c < 64; c++)
          h[a + b + c]++;
    step(8);
    rst_n_i = 1'b1;
    step(2);
    check_state();
    check(32'(valid), 32'h0);
    for (int sc = 0; sc < 8; sc++) begin
      setup(sc);
      cmp_en = 2'h3;
      step(2);
      adc_en = (sc == 2) ? 2'h1 : 2'h3;
      for (int i = 0; i < 12000 && seen_n[0] < 5; i++) step(1);
      if (seen_n[0] < 5) begin
        n_fail++; // results never arrived: straight to the verdict
        break;
      end
      finish_sc();
      $display("test %0d done", sc);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
